/* File: ifm_map.svh */
`ifndef IFM_MAP_SVH
`define IFM_MAP_SVH
`define IFM_ADDR_FLAGS_A 16'hFFE0
`define IFM_ADDR_FLAGS_B 16'hFFE1
`define IFM_ADDR_FLAGS_C 16'hFFE2
`define IFM_ADDR_MASK_A 16'hFFE4
`define IFM_ADDR_MASK_B 16'hFFE5
`define IFM_ADDR_MASK_C 16'hFFE6
`define IFM_FLAGS_RESET 8'h00
`define IFM_MASK_RESET 8'hFF
`define IFM_C_FIXED_MASK 8'hC0
`define IFM_NSRC 22
`define IFM_WDT_BIT 0
`endif

/* File: ifm_pkg.sv */
package ifm_pkg;
    typedef enum logic [1:0] {
        IFM_WD_INTERVAL,
        IFM_WD_MODE1,
        IFM_WD_MODE2
    } ifm_wd_mode_e;
    // CPU memory access: bit ops write the single bit at bit_idx in the bank, with no core read
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic bit_op;
        logic [2:0] bit_idx;
    } ifm_cpu_req_s;
    typedef struct packed {
        logic valid;
        logic nmi;
        logic [4:0] index;
    } ifm_select_s;
endpackage

/* File: ifm_flag_mask_bank.sv */
// Summary of operation
// - Flag sets on source request or write one
// - Flag clears on acknowledge, reset, write zero
// - Flag one means request pending
// - Reset clears all three flag bytes
// - Mask zero enables, one blocks servicing
// - Reset sets all mask bytes to ones
// - Flags at three consecutive bytes, C[7:6]=0
// - Masks mirror flag positions, C[7:6]=1
// - One flag and mask per request line
// - Bit and byte access to both banks
// - Watchdog flag usable only in interval mode
// - Watchdog mask reads undefined in modes 1,2
// - Eligible needs flag one and mask zero
// - Fixed priority, index zero highest
// - Watchdog non-maskable request always wins
`include "ifm_map.svh"
module ifm_flag_mask_bank #(
    parameter int NSRC = `IFM_NSRC
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire ifm_pkg::ifm_cpu_req_s cpu_req,
    output logic [7:0] cpu_rdata,
    output logic cpu_hit,
    input wire logic [NSRC-1:0] src_req,
    input wire ifm_pkg::ifm_wd_mode_e wd_mode,
    input wire logic wd_overflow,
    input wire logic global_irq_enable,
    input wire logic ack,
    input wire logic [4:0] ack_index,
    input wire logic ack_nmi,
    output ifm_pkg::ifm_select_s irq_select,
    output logic irq_pending
);
    logic rst_s1_r, rst_n_r;
    logic [23:0] flags_r, flags_nxt;
    logic [23:0] mask_r, mask_nxt;
    logic [23:0] wmask, wval, src24, ack24;
    logic [23:0] eligible;
    logic [7:0] rbyte;
    logic [1:0] sel;
    logic sel_flag, sel_mask;
    logic wd_interval, nmi_pend_r;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    assign wd_interval = (wd_mode == ifm_pkg::IFM_WD_INTERVAL);

    // Byte decode; addresses 3 and 7 of the window are holes
    always_comb begin
        sel_flag = 1'b0;
        sel_mask = 1'b0;
        sel = 2'd0;
        case (cpu_req.addr)
            `IFM_ADDR_FLAGS_A: begin sel_flag = 1'b1; sel = 2'd0; end
            `IFM_ADDR_FLAGS_B: begin sel_flag = 1'b1; sel = 2'd1; end
            `IFM_ADDR_FLAGS_C: begin sel_flag = 1'b1; sel = 2'd2; end
            `IFM_ADDR_MASK_A: begin sel_mask = 1'b1; sel = 2'd0; end
            `IFM_ADDR_MASK_B: begin sel_mask = 1'b1; sel = 2'd1; end
            `IFM_ADDR_MASK_C: begin sel_mask = 1'b1; sel = 2'd2; end
            default: sel = 2'd0;
        endcase
    end
    assign cpu_hit = sel_flag | sel_mask;

    // Write lanes: bit op touches one bit, byte op all eight
    always_comb begin
        wmask = '0;
        wval = '0;
        if (cpu_req.wr && cpu_hit) begin
            if (cpu_req.bit_op)
                wmask[{sel, 3'b000} + 5'(cpu_req.bit_idx)] = 1'b1;
            else
                wmask[{sel, 3'b000} +: 8] = 8'hFF;
            wval[{sel, 3'b000} +: 8] = cpu_req.wdata;
        end
    end

    // Serial A receive and transfer share one line at index 6 upstream
    assign src24 = {2'b00, src_req};
    always_comb begin
        ack24 = '0;
        if (ack && !ack_nmi)
            ack24[ack_index] = 1'b1;
    end

    // Source set is applied after write and acknowledge so it beats a same-cycle clear from either
    always_comb begin
        flags_nxt = flags_r;
        if (sel_flag)
            flags_nxt = (flags_r & ~wmask) | (wval & wmask);
        flags_nxt = flags_nxt & ~ack24;
        flags_nxt = flags_nxt | src24;
        if (!wd_interval)
            flags_nxt[`IFM_WDT_BIT] = 1'b0;
        flags_nxt[23:22] = 2'b00;
    end

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r)
            flags_r <= {3{`IFM_FLAGS_RESET}};
        else
            flags_r <= flags_nxt;
    end

    always_comb begin
        mask_nxt = mask_r;
        if (sel_mask)
            mask_nxt = (mask_r & ~wmask) | (wval & wmask);
        mask_nxt[23:22] = 2'b11;
    end

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r)
            mask_r <= {3{`IFM_MASK_RESET}};
        else
            mask_r <= mask_nxt;
    end

    // Watchdog non-maskable request latched in modes 1 and 2
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r)
            nmi_pend_r <= 1'b0;
        else if (wd_overflow && !wd_interval)
            nmi_pend_r <= 1'b1;
        else if (ack && ack_nmi)
            nmi_pend_r <= 1'b0;
    end

    always_comb begin
        rbyte = sel_flag ? flags_r[{sel, 3'b000} +: 8]
                         : mask_r[{sel, 3'b000} +: 8];
        // Undefined value chosen as zero here
        if (sel_mask && sel == 2'd0 && !wd_interval)
            rbyte[`IFM_WDT_BIT] = 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r)
            cpu_rdata <= 8'h00;
        else if (cpu_req.rd)
            cpu_rdata <= cpu_hit ? rbyte : 8'h00;
    end

    assign eligible = flags_r & ~mask_r;

    // Lowest index wins; loop runs high to low so index 0 ends up last
    always_comb begin
        irq_select = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (eligible[i] && global_irq_enable) begin
                irq_select.valid = 1'b1;
                irq_select.index = 5'(i);
            end
        end
        if (nmi_pend_r) begin
            irq_select.valid = 1'b1;
            irq_select.nmi = 1'b1;
            irq_select.index = 5'(`IFM_WDT_BIT);
        end
    end
    assign irq_pending = irq_select.valid;

    // Acknowledge of a maskable line with no competing source request
    sequence s_plain_ack;
        ack && !ack_nmi && ack_index < 5'(NSRC) && !src_req[ack_index];
    endsequence

    a_reset_masks: assert property (
        @(posedge clock)
        $rose(rst_n_r) |-> mask_r == 24'hFFFFFF && flags_r == 24'h000000)
        else $error("bank not at reset values");
    a_source_sets: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        src_req[NSRC-1:1] != '0 |=>
        (flags_r[NSRC-1:1] & $past(src_req[NSRC-1:1])) ==
        $past(src_req[NSRC-1:1]))
        else $error("source request lost");
    a_ack_clears: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        s_plain_ack |=> !flags_r[$past(ack_index)])
        else $error("acknowledge did not clear");
    a_fixed_top: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        mask_r[23:22] == 2'b11 && flags_r[23:22] == 2'b00)
        else $error("fixed bits wrong");
    a_masked_blocked: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        irq_select.valid && !irq_select.nmi |-> global_irq_enable &&
        !mask_r[irq_select.index] && flags_r[irq_select.index])
        else $error("masked source selected");
    a_ie_gate: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        !global_irq_enable && !nmi_pend_r |-> !irq_select.valid)
        else $error("request selected while disabled");
    a_nmi_first: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        nmi_pend_r |-> irq_select.nmi && irq_select.valid &&
        irq_select.index == 5'h00)
        else $error("nmi not preferred");
    a_prio_zero: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        eligible[0] && global_irq_enable && !nmi_pend_r |->
        irq_select.index == 5'h00)
        else $error("priority order wrong");
    a_prio_order: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        irq_select.valid && !irq_select.nmi |-> (eligible &
        ((24'h000001 << irq_select.index) - 24'h000001)) == 24'h000000)
        else $error("lower priority source selected");
    a_wdt_flag: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        !wd_interval |=> !flags_r[`IFM_WDT_BIT])
        else $error("watchdog flag set outside interval");
    a_wdt_mask_read: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        cpu_req.rd && sel_mask && sel == 2'h0 && !wd_interval
        |=> !cpu_rdata[`IFM_WDT_BIT])
        else $error("watchdog mask read not zero");
    a_mask_write: assert property (
        @(posedge clock) disable iff (!rst_n_r)
        cpu_req.wr && cpu_req.addr == `IFM_ADDR_MASK_A && !cpu_req.bit_op
        |=> mask_r[7:0] == $past(cpu_req.wdata))
        else $error("mask byte write lost");
endmodule // ifm_flag_mask_bank

/* File: ifm_src_model.sv */
module ifm_src_model (
    input wire logic clock,
    output logic [21:0] src_req,
    output logic ack,
    output logic [4:0] ack_index,
    output logic ack_nmi,
    output logic wd_overflow
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        src_req = '0;
        ack = 1'b0;
        ack_index = 5'h00;
        ack_nmi = 1'b0;
        wd_overflow = 1'b0;
    end
    // Single-cycle request pulse, as a peripheral event would give
    task raise(input int i);
        @(negedge clock);
        src_req[i] = 1'b1;
        @(negedge clock);
        src_req = '0;
    endtask
    // Core acknowledge; index left stale afterwards on purpose
    task acknowledge(input logic [4:0] i, input logic nmi = 1'b0);
        @(negedge clock);
        ack = 1'b1;
        ack_index = i;
        ack_nmi = nmi;
        @(negedge clock);
        ack = 1'b0;
        ack_nmi = 1'b0;
    endtask
    // Overflow pulse; only latched while the watchdog is not an interval
    task overflow;
        @(negedge clock);
        wd_overflow = 1'b1;
        @(negedge clock);
        wd_overflow = 1'b0;
    endtask
endmodule // ifm_src_model

/* File: tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, arst_n, hit, pend, ack, ack_nmi, wdo;
    logic [7:0] rdata;
    logic [21:0] src;
    logic [4:0] ack_idx;
    ifm_pkg::ifm_cpu_req_s req;
    ifm_pkg::ifm_select_s sel;
    ifm_pkg::ifm_wd_mode_e wdm;
    logic gie;
    int failures, n_checks;
    ifm_flag_mask_bank u_ifm_flag_mask_bank (.clock(clock),
        .arst_n(arst_n), .cpu_req(req), .cpu_rdata(rdata), .cpu_hit(hit),
        .src_req(src), .wd_mode(wdm),
        .wd_overflow(wdo), .global_irq_enable(gie), .ack(ack),
        .ack_index(ack_idx), .ack_nmi(ack_nmi), .irq_select(sel),
        .irq_pending(pend));
    ifm_src_model u_ifm_src_model (.clock(clock), .src_req(src), .ack(ack),
        .ack_index(ack_idx), .ack_nmi(ack_nmi), .wd_overflow(wdo));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task check(input string what, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d,
            input logic bo = 1'b0, input logic [2:0] bi = 3'h0);
        @(negedge clock);
        req = '0;
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        req.bit_op = bo;
        req.bit_idx = bi;
        @(negedge clock);
        req = '0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clock);
        req = '0;
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clock);
        req = '0;
        check("rdata", rdata, e);
    endtask
    task t_reset;
        rd(16'hFFE0, 8'h00);
        rd(16'hFFE1, 8'h00);
        rd(16'hFFE2, 8'h00);
        rd(16'hFFE4, 8'hFF);
        rd(16'hFFE5, 8'hFF);
        rd(16'hFFE6, 8'hFF);
        rd(16'hFFE3, 8'h00);
        @(negedge clock);
        req.addr = 16'hFFE3;
        @(negedge clock);
        check("hit hole", {7'h00, hit}, 8'h00);
        req.addr = 16'hFFE6;
        @(negedge clock);
        check("hit mask", {7'h00, hit}, 8'h01);
        req = '0;
        $display("test reset done");
    endtask
    task t_fields;
        wr(16'hFFE2, 8'hFF);
        rd(16'hFFE2, 8'h3F);
        wr(16'hFFE6, 8'h00);
        rd(16'hFFE6, 8'hC0);
        wr(16'hFFE1, 8'h20, 1'b1, 3'h5);
        wr(16'hFFE1, 8'h00, 1'b1, 3'h0);
        rd(16'hFFE1, 8'h20);
        wr(16'hFFE2, 8'h00);
        wr(16'hFFE1, 8'h00);
        $display("test fields done");
    endtask
    task t_service;
        wr(16'hFFE4, 8'hF7);
        u_ifm_src_model.raise(1);
        check("pend masked", {7'h00, pend}, 8'h00);
        u_ifm_src_model.raise(3);
        check("index", {3'h0, sel.index}, 8'h03);
        wr(16'hFFE4, 8'h00);
        check("priority", {3'h0, sel.index}, 8'h01);
        u_ifm_src_model.acknowledge(5'h01);
        rd(16'hFFE0, 8'h08);
        u_ifm_src_model.acknowledge(5'h03);
        check("pend idle", {7'h00, pend}, 8'h00);
        $display("test service done");
    endtask
    task t_race;
        fork
            u_ifm_src_model.raise(4);
            wr(16'hFFE0, 8'h00);
        join
        rd(16'hFFE0, 8'h10);
        $display("test race done");
    endtask
    task t_gate;
        @(negedge clock);
        gie = 1'b0;
        @(negedge clock);
        check("pend gated", {7'h00, pend}, 8'h00);
        gie = 1'b1;
        @(negedge clock);
        check("pend open", {7'h00, pend}, 8'h01);
        check("index open", {3'h0, sel.index}, 8'h04);
        u_ifm_src_model.acknowledge(5'h04);
        rd(16'hFFE0, 8'h00);
        $display("test gate done");
    endtask
    task t_pins;
        // Pin mask goes up before the shared port starts driving
        wr(16'hFFE4, 8'h04, 1'b1, 3'h2);
        u_ifm_src_model.raise(2);
        check("pin masked", {7'h00, pend}, 8'h00);
        rd(16'hFFE0, 8'h04);
        wr(16'hFFE0, 8'h00, 1'b1, 3'h2);
        wr(16'hFFE4, 8'h00, 1'b1, 3'h2);
        rd(16'hFFE0, 8'h00);
        check("pin idle", {7'h00, pend}, 8'h00);
        $display("test pins done");
    endtask
    task t_watchdog;
        wr(16'hFFE0, 8'h01);
        u_ifm_src_model.raise(5);
        check("index wdt", {3'h0, sel.index}, 8'h00);
        wr(16'hFFE4, 8'h01);
        check("index next", {3'h0, sel.index}, 8'h05);
        rd(16'hFFE4, 8'h01);
        @(negedge clock);
        wdm = ifm_pkg::IFM_WD_MODE1;
        gie = 1'b0;
        u_ifm_src_model.raise(0);
        rd(16'hFFE0, 8'h20);
        rd(16'hFFE4, 8'h00);
        u_ifm_src_model.overflow();
        check("nmi", {6'h00, sel.nmi, pend}, 8'h03);
        check("nmi index", {3'h0, sel.index}, 8'h00);
        u_ifm_src_model.acknowledge(5'h00, 1'b1);
        check("nmi done", {7'h00, pend}, 8'h00);
        @(negedge clock);
        wdm = ifm_pkg::IFM_WD_INTERVAL;
        gie = 1'b1;
        u_ifm_src_model.acknowledge(5'h05);
        wr(16'hFFE4, 8'h00);
        rd(16'hFFE0, 8'h00);
        $display("test watchdog done");
    endtask
    task t_rerun;
        wr(16'hFFE5, 8'h00);
        u_ifm_src_model.raise(7);
        @(negedge clock);
        arst_n = 1'b0;
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        check("pend reset", {7'h00, pend}, 8'h00);
        rd(16'hFFE5, 8'hFF);
        rd(16'hFFE0, 8'h00);
        $display("test rerun done");
    endtask
    task summarize;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #1ms;
        failures++;
        summarize;
    end
    initial begin
        failures = 0;
        n_checks = 0;
        req = '0;
        wdm = ifm_pkg::IFM_WD_INTERVAL;
        gie = 1'b1;
        arst_n = 1'b0;
        repeat (8) @(negedge clock);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        t_reset;
        t_fields;
        t_service;
        t_race;
        t_gate;
        t_pins;
        t_watchdog;
        t_rerun;
        summarize;
    end
endmodule // tb_top
